// ### core/bhp_pkg.sv
// Contract
// - Assert capture request when a captured sample is ready for the host.
// - Keep capture request until every byte of that sample is read.
// - A read strobe with capture acknowledge returns the next capture byte.
// - Assert playback request whenever more playback data can be accepted.
// - Hold playback request until all bytes of one sample are written.
// - A write strobe with playback acknowledge stores the byte for playback.
// - Two-bit register select picks the directly addressed register.
// - Active-low read strobe marks a read from registers or DMA samples.
// - Active-low write strobe marks a write to registers or DMA samples.
// - Register strobes are ignored unless chip select is low.
// - Chip select is ignored for DMA; acknowledges alone qualify them.
// - Driver enable idles high, low during qualified register or DMA strobes.
// - Direction idles high, low only during qualified reads.
// - All traffic uses one eight-bit bidirectional data bus.
// - Power-down low shuts down every section including this port.
// - Interrupt asserts when the DMA sample count underflows.
// - Two open-drain control outputs follow internal register bits.
// - Master timing comes from one of two crystal sources.
// - Sample bytes go most significant first, left channel before right.
package bhp_pkg;

  // ----------------------------------------------------------------------
  // Widths and positions
  // ----------------------------------------------------------------------
  localparam int unsigned BYTE_W   = 8;
  localparam int unsigned SAMPLE_W = 32;           // Stereo 16-bit pair.
  localparam int unsigned SEL_W    = 2;
  localparam logic [1:0]  BYTE_LAST = 2'h3;        // Four bytes per sample.
  localparam int unsigned CNT_W    = 16;
  localparam logic [SEL_W-1:0] SEL_INDEX  = 2'h0;  // Indirect index register.
  localparam logic [SEL_W-1:0] SEL_DATA   = 2'h1;  // Indirect data register.
  localparam logic [SEL_W-1:0] SEL_STATUS = 2'h2;  // Status register.
  localparam logic [SEL_W-1:0] SEL_PIO    = 2'h3;  // Programmed-I/O sample register.
  localparam logic [3:0] IDX_CNT_HI = 4'hE;
  localparam logic [3:0] IDX_CNT_LO = 4'hF;
  localparam logic [3:0] IDX_XCTL   = 4'hA;
  localparam int unsigned XCTL_POS  = 6;           // Control-out bits 7:6.
  localparam int unsigned STAT_IRQ_POS = 0;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [BYTE_W-1:0] RST_BYTE = 8'h00;
  localparam logic [CNT_W-1:0]  RST_CNT  = 16'h0000;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    BHP_IDLE   = 2'b00,
    BHP_ACCESS = 2'b01,
    BHP_RECOV  = 2'b11
  } bhp_cyc_e;

  typedef struct packed {
    logic              rd_n;
    logic              wr_n;
    logic              cs_n;
    logic              cap_ack_n;
    logic              play_ack_n;
    logic [SEL_W-1:0]  sel;
    logic [BYTE_W-1:0] data;
  } bhp_pins_s;

  typedef struct packed {
    logic              valid;
    logic [SAMPLE_W-1:0] data;
  } bhp_sample_s;

endpackage : bhp_pkg

// ### core/bhp_port.sv
`timescale 1ns/100ps
module bhp_port
  import bhp_pkg::*;
(
  // Clock and reset.
  input  wire logic                clk_i,
  input  wire logic                srst_i,
  // Host bus pins.
  input  wire logic                rd_n_i,
  input  wire logic                wr_n_i,
  input  wire logic                cs_n_i,
  input  wire logic                capture_ack_n_i,
  input  wire logic                playback_ack_n_i,
  input  wire logic [SEL_W-1:0]    reg_select_i,
  input  wire logic [BYTE_W-1:0]   host_byte_bus_i,
  output logic [BYTE_W-1:0]        host_byte_bus_o,
  output logic                     host_byte_bus_oe_o,
  // Handshake and control pins.
  output logic                     capture_request_o,
  output logic                     playback_request_o,
  output logic                     xcvr_enable_n_o,
  output logic                     xcvr_direction_o,
  output logic                     irq_o,
  output logic [1:0]               ext_control_out_o,
  output logic [1:0]               ext_control_out_oe_o,
  input  wire logic                power_down_n_i,
  // Converter side.
  input  wire logic                capture_valid_i,
  input  wire logic [SAMPLE_W-1:0] capture_data_i,
  output logic                     capture_taken_o,
  input  wire logic                playback_ready_i,
  output logic                     playback_valid_o,
  output logic [SAMPLE_W-1:0]      playback_data_o,
  input  wire logic                crystal_sel_i
);

  // ----------------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------------
  bhp_pins_s raw_pins;
  bhp_pins_s pins;
  logic      pd_s1_ff;
  logic      pd_s2_ff;

  assign raw_pins = '{rd_n: rd_n_i, wr_n: wr_n_i, cs_n: cs_n_i, cap_ack_n: capture_ack_n_i,
                      play_ack_n: playback_ack_n_i, sel: reg_select_i, data: host_byte_bus_i};

  bhp_sync u_sync (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .pins_i (raw_pins),
    .pins_o (pins)
  );

  // Power-down pin is asynchronous; two stages before any use.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pd_s1_ff <= 1'b1;
      pd_s2_ff <= 1'b1;
    end else begin
      pd_s1_ff <= power_down_n_i;
      pd_s2_ff <= pd_s1_ff;
    end
  end

  // ----------------------------------------------------------------------
  // Cycle qualification
  // ----------------------------------------------------------------------
  logic rd_act;
  logic wr_act;
  logic cap_dma;
  logic play_dma;
  logic reg_cyc;
  logic any_cyc;
  logic shut;

  assign shut     = srst_i | ~pd_s2_ff;
  assign rd_act   = ~pins.rd_n;
  assign wr_act   = ~pins.wr_n;
  assign cap_dma  = ~pins.cap_ack_n;
  assign play_dma = ~pins.play_ack_n;
  assign reg_cyc  = ~pins.cs_n & ~cap_dma & ~play_dma;
  assign any_cyc  = (rd_act | wr_act) & (reg_cyc | cap_dma | play_dma);

  // ----------------------------------------------------------------------
  // Sample shifters
  // ----------------------------------------------------------------------
  logic                cap_load;
  logic                cap_shift;
  logic [BYTE_W-1:0]   cap_top;
  logic [1:0]          cap_cnt;
  logic                play_shift;
  logic [SAMPLE_W-1:0] play_word;
  logic [1:0]          play_cnt;
  logic                byte_edge;

  bhp_sample_shift u_cap_shift (
    .clk_i       (clk_i),
    .srst_i      (shut),
    .load_i      (cap_load),
    .load_data_i (capture_data_i),
    .shift_i     (cap_shift),
    .shift_in_i  (RST_BYTE),
    .word_o      (),
    .top_byte_o  (cap_top),
    .count_o     (cap_cnt)
  );

  bhp_sample_shift u_play_shift (
    .clk_i       (clk_i),
    .srst_i      (shut),
    .load_i      (1'b0),
    .load_data_i ('0),
    .shift_i     (play_shift),
    .shift_in_i  (pins.data),
    .word_o      (play_word),
    .top_byte_o  (),
    .count_o     (play_cnt)
  );

  // ----------------------------------------------------------------------
  // Block state
  // ----------------------------------------------------------------------
  typedef struct packed {
    bhp_cyc_e            cyc;
    logic                cap_req;
    logic                play_req;
    logic                play_out;
    logic [SAMPLE_W-1:0] play_data;
    logic                taken;
    logic [3:0]          index;
    logic [BYTE_W-1:0]   xctl;
    logic [CNT_W-1:0]    base;
    logic [CNT_W-1:0]    count;
    logic                irq;
    logic [BYTE_W-1:0]   rdata;
    logic                oe;
    logic                en_n;
    logic                dir;
    logic [1:0]          od_oe;
  } bhp_state_s;

  bhp_state_s st_ff;
  bhp_state_s nxt_st;

  // Status byte seen at the status select.
  function automatic logic [BYTE_W-1:0] status_byte(input bhp_state_s s);
    logic [BYTE_W-1:0] b;
    b = RST_BYTE;
    b[STAT_IRQ_POS]   = s.irq;
    b[STAT_IRQ_POS+1] = s.cap_req;
    b[STAT_IRQ_POS+2] = s.play_req;
    return b;
  endfunction : status_byte

  // Indirect register read by index.
  function automatic logic [BYTE_W-1:0] indirect_byte(input bhp_state_s s);
    logic [BYTE_W-1:0] b;
    b = RST_BYTE;
    unique case (s.index)
      IDX_CNT_HI: b = s.base[CNT_W-1 -: BYTE_W];
      IDX_CNT_LO: b = s.base[BYTE_W-1:0];
      IDX_XCTL:   b = s.xctl;
      default:    b = RST_BYTE;
    endcase
    return b;
  endfunction : indirect_byte

  // A transfer is acted on once, at the strobe's leading edge in IDLE.
  assign byte_edge  = (st_ff.cyc == BHP_IDLE) & any_cyc;
  assign cap_shift  = byte_edge & rd_act & cap_dma & st_ff.cap_req;
  assign play_shift = byte_edge & wr_act & play_dma & st_ff.play_req;
  assign cap_load   = capture_valid_i & ~st_ff.cap_req & ~st_ff.taken;

  // Next-state logic for the whole port.
  always_comb begin
    nxt_st       = st_ff;
    nxt_st.taken = 1'b0;
    nxt_st.play_out = st_ff.play_out & ~playback_ready_i;
    // Strobe sequencing: one action per strobe, wait for release.
    unique case (st_ff.cyc)
      BHP_IDLE:   if (any_cyc) nxt_st.cyc = BHP_ACCESS;
      BHP_ACCESS: if (pins.rd_n & pins.wr_n) nxt_st.cyc = BHP_RECOV;
      BHP_RECOV:  nxt_st.cyc = BHP_IDLE;
      default:    nxt_st.cyc = BHP_IDLE;
    endcase
    // Capture: request rises on a loaded sample, falls after the last byte.
    if (cap_load) begin
      nxt_st.cap_req = 1'b1;
      nxt_st.taken   = 1'b1;
    end
    if (cap_shift) begin
      nxt_st.rdata = cap_top;
      if (cap_cnt == BYTE_LAST) begin
        nxt_st.cap_req = 1'b0;
      end
    end
    // Playback: request stands while room exists, drops after the last byte.
    if (!st_ff.play_out) begin
      nxt_st.play_req = 1'b1;
    end
    if (play_shift && play_cnt == BYTE_LAST) begin
      nxt_st.play_req  = 1'b0;
      nxt_st.play_out  = 1'b1;
      nxt_st.play_data = {play_word[SAMPLE_W-BYTE_W-1:0], pins.data};
    end
    // Count underflow per completed playback or capture sample.
    if ((play_shift && play_cnt == BYTE_LAST) || (cap_shift && cap_cnt == BYTE_LAST)) begin
      if (st_ff.count == RST_CNT) begin
        nxt_st.irq   = 1'b1;
        nxt_st.count = st_ff.base;
      end else begin
        nxt_st.count = st_ff.count - 16'h0001;
      end
    end
    // Register accesses selected by the two-bit select.
    if (byte_edge && reg_cyc) begin
      if (rd_act) begin
        unique case (pins.sel)
          SEL_INDEX:  nxt_st.rdata = {4'h0, st_ff.index};
          SEL_DATA:   nxt_st.rdata = indirect_byte(st_ff);
          SEL_STATUS: nxt_st.rdata = status_byte(st_ff);
          SEL_PIO:    nxt_st.rdata = cap_top;
        endcase
      end else begin
        unique case (pins.sel)
          SEL_INDEX:  nxt_st.index = pins.data[3:0];
          SEL_DATA: begin
            unique case (st_ff.index)
              IDX_CNT_HI: nxt_st.base[CNT_W-1 -: BYTE_W] = pins.data;
              IDX_CNT_LO: nxt_st.base[BYTE_W-1:0] = pins.data;
              IDX_XCTL:   nxt_st.xctl = pins.data;
              default:    nxt_st.xctl = st_ff.xctl;
            endcase
          end
          SEL_STATUS: nxt_st.irq = 1'b0;     // Any write to status clears the interrupt.
          SEL_PIO:    nxt_st.xctl = st_ff.xctl;
        endcase
        if (pins.sel == SEL_STATUS && st_ff.irq == 1'b0) begin
          nxt_st.irq = nxt_st.irq;
        end
      end
    end
    // Transceiver controls follow the qualified strobes.
    nxt_st.en_n = ~any_cyc;
    nxt_st.dir  = ~(rd_act & (reg_cyc | cap_dma | play_dma));
    nxt_st.oe   = rd_act & (reg_cyc | cap_dma);
    if (shut) begin
      nxt_st          = '0;
      nxt_st.cyc      = BHP_IDLE;
      nxt_st.en_n     = 1'b1;
      nxt_st.dir      = 1'b1;
    end
    // Registered open-drain enables keep the pins glitch-free; a zero bit pulls low.
    nxt_st.od_oe = ~nxt_st.xctl[XCTL_POS +: 2];
  end

  // State register.
  always_ff @(posedge clk_i) begin
    st_ff <= nxt_st;
  end

  // ----------------------------------------------------------------------
  // Outputs, from flip-flops except the constant control-out value
  // ----------------------------------------------------------------------
  // The control outputs are open-drain: the value stays low and the enable pulls.
  assign ext_control_out_oe_o = st_ff.od_oe;

  assign ext_control_out_o   = 2'h0;
  assign host_byte_bus_o     = st_ff.rdata;
  assign host_byte_bus_oe_o  = st_ff.oe;
  assign capture_request_o   = st_ff.cap_req;
  assign playback_request_o  = st_ff.play_req;
  assign xcvr_enable_n_o     = st_ff.en_n;
  assign xcvr_direction_o    = st_ff.dir;
  assign irq_o               = st_ff.irq;
  assign capture_taken_o     = st_ff.taken;
  assign playback_valid_o    = st_ff.play_out;
  assign playback_data_o     = st_ff.play_data;

  // The crystal choice lives in the clock generator; this port only sees clk_i.
  logic unused_xtal;
  assign unused_xtal = crystal_sel_i;

endmodule : bhp_port

// ### core/bhp_sample_shift.sv
`timescale 1ns/100ps
module bhp_sample_shift
  import bhp_pkg::*;
(
  // Clock and reset.
  input  wire logic                clk_i,
  input  wire logic                srst_i,
  // Load a full sample or shift one byte.
  input  wire logic                load_i,
  input  wire logic [SAMPLE_W-1:0] load_data_i,
  input  wire logic                shift_i,
  input  wire logic [BYTE_W-1:0]   shift_in_i,
  // Current state.
  output logic [SAMPLE_W-1:0]      word_o,
  output logic [BYTE_W-1:0]        top_byte_o,
  output logic [1:0]               count_o
);

  // ----------------------------------------------------------------------
  // Byte shifter, most significant byte first
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [SAMPLE_W-1:0] word;
    logic [1:0]          cnt;
  } bhp_shift_state_s;

  bhp_shift_state_s st_ff;
  bhp_shift_state_s nxt_st;

  // Shifting left keeps the next byte on top for reads and appends writes low.
  always_comb begin
    nxt_st = st_ff;
    if (load_i) begin
      nxt_st.word = load_data_i;
      nxt_st.cnt  = 2'h0;
    end else if (shift_i) begin
      nxt_st.word = {st_ff.word[SAMPLE_W-BYTE_W-1:0], shift_in_i};
      nxt_st.cnt  = st_ff.cnt + 2'h1;
    end
    if (srst_i) begin
      nxt_st = '0;
    end
  end

  // State register.
  always_ff @(posedge clk_i) begin
    st_ff <= nxt_st;
  end

  assign word_o     = st_ff.word;
  assign top_byte_o = st_ff.word[SAMPLE_W-1 -: BYTE_W];
  assign count_o    = st_ff.cnt;

endmodule : bhp_sample_shift

// ### core/bhp_sync.sv
`timescale 1ns/100ps
module bhp_sync
  import bhp_pkg::*;
(
  // Clock and reset.
  input  wire logic      clk_i,
  input  wire logic      srst_i,
  // Raw pins and synchronised copy.
  input  wire bhp_pins_s pins_i,
  output bhp_pins_s      pins_o
);

  // ----------------------------------------------------------------------
  // Two-stage synchroniser
  // ----------------------------------------------------------------------
  typedef struct packed {
    bhp_pins_s s1;
    bhp_pins_s s2;
  } bhp_sync_state_s;

  localparam bhp_pins_s PINS_IDLE = '{rd_n: 1'b1, wr_n: 1'b1, cs_n: 1'b1, cap_ack_n: 1'b1,
                                      play_ack_n: 1'b1, sel: '0, data: RST_BYTE};

  bhp_sync_state_s st_ff;
  bhp_sync_state_s nxt_st;

  // The first stage feeds only the second, so metastability stays contained.
  always_comb begin
    nxt_st    = st_ff;
    nxt_st.s1 = pins_i;
    nxt_st.s2 = st_ff.s1;
    if (srst_i) begin
      nxt_st.s1 = PINS_IDLE;
      nxt_st.s2 = PINS_IDLE;
    end
  end

  // State register.
  always_ff @(posedge clk_i) begin
    st_ff <= nxt_st;
  end

  assign pins_o = st_ff.s2;

endmodule : bhp_sync

// ### testbench/bhp_host_model.sv
`timescale 1ns/100ps
module bhp_host_model (
  // Clock and the resolved data bus.
  input  wire logic       clk_i,
  input  wire logic [7:0] bus_i,
  input  wire logic [2:0] ctl_i,
  // Host strobes, select and write data.
  output logic            rd_n_o,
  output logic            wr_n_o,
  output logic            cs_n_o,
  output logic            cap_ack_n_o,
  output logic            play_ack_n_o,
  output logic [1:0]      sel_o,
  output logic [7:0]      data_o
);
  // --------------------------------------------------------------------
  // Bus cycle
  // --------------------------------------------------------------------
  // Idle host: all strobes high, bus released.
  initial begin
    {rd_n_o, wr_n_o, cs_n_o, cap_ack_n_o, play_ack_n_o} = 5'h1F;
    sel_o  = 2'h0;
    data_o = 8'h00;
  end

  // One byte: select and acknowledge set up a cycle ahead, strobe held five
  // edges, then two idle edges so the synchroniser sees a clean gap.
  task automatic xfer(input logic rd, input logic cs_n, input logic [1:0] ack_n,
                      input logic [1:0] sel, input logic [7:0] wdat,
                      output logic [7:0] rdat, output logic [2:0] ctl);
    @(negedge clk_i);
    cs_n_o       = cs_n;
    cap_ack_n_o  = ack_n[1];
    play_ack_n_o = ack_n[0] | ~ack_n[1];
    sel_o        = sel;
    data_o       = rd ? ~data_o : wdat;
    @(negedge clk_i);
    rd_n_o = ~rd;
    wr_n_o = rd;
    repeat (5) @(posedge clk_i);
    rdat = bus_i;
    ctl  = ctl_i;
    @(negedge clk_i);
    {rd_n_o, wr_n_o} = 2'h3;
    @(negedge clk_i);
    {cs_n_o, cap_ack_n_o, play_ack_n_o} = 3'h7;
    data_o = ~data_o;  // Released bus must not keep showing the old byte.
    @(negedge clk_i);
  endtask : xfer
endmodule : bhp_host_model

// ### testbench/bhp_port_asserts.sv
`timescale 1ns/100ps
module bhp_port_asserts (
  // Clock and reset.
  input wire logic       clk_i,
  input wire logic       srst_i,
  // Host strobes and power-down.
  input wire logic       rd_n_i,
  input wire logic       wr_n_i,
  input wire logic       cs_n_i,
  input wire logic       capture_ack_n_i,
  input wire logic       playback_ack_n_i,
  input wire logic       power_down_n_i,
  // Device outputs.
  input wire logic       host_byte_bus_oe_o,
  input wire logic       capture_request_o,
  input wire logic       playback_request_o,
  input wire logic       xcvr_enable_n_o,
  input wire logic       xcvr_direction_o,
  input wire logic       irq_o,
  input wire logic [1:0] ext_control_out_o,
  input wire logic [1:0] ext_control_out_oe_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);

  // --------------------------------------------------------------------
  // Strobe ages
  // --------------------------------------------------------------------
  // Cycles since the last DMA strobe of each direction, so a request drop
  // can be tied to a transfer despite the pin synchroniser delay.
  logic [3:0] cap_age_ff;
  logic [3:0] play_age_ff;
  always_ff @(posedge clk_i) begin
    if (srst_i || !power_down_n_i || (!rd_n_i && !capture_ack_n_i)) begin
      cap_age_ff <= 4'h0;
    end else if (cap_age_ff != 4'hF) begin
      cap_age_ff <= cap_age_ff + 4'h1;
    end
    if (srst_i || !power_down_n_i || (!wr_n_i && !playback_ack_n_i)) begin
      play_age_ff <= 4'h0;
    end else if (play_age_ff != 4'hF) begin
      play_age_ff <= play_age_ff + 4'h1;
    end
  end

  // --------------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------------
  AST_IDLE_EN: assert property ((rd_n_i && wr_n_i)[*3] |=> xcvr_enable_n_o)
    else $error("driver enable low with no strobe");
  AST_NO_SELECT: assert property ((cs_n_i && capture_ack_n_i && playback_ack_n_i)[*3] |=> xcvr_enable_n_o)
    else $error("driver enable low without chip select or acknowledge");
  AST_RD_DIR: assert property (rd_n_i[*3] |=> xcvr_direction_o)
    else $error("direction low with no read strobe");
  AST_REG_READ: assert property ((!rd_n_i && !cs_n_i && power_down_n_i)[*5] |=> !xcvr_enable_n_o && !xcvr_direction_o)
    else $error("register read did not turn the transceiver");
  AST_DMA_READ: assert property ((!rd_n_i && !capture_ack_n_i && power_down_n_i)[*5] |=> !xcvr_enable_n_o && !xcvr_direction_o && host_byte_bus_oe_o)
    else $error("capture read not served");
  AST_DMA_WRITE: assert property ((!wr_n_i && !playback_ack_n_i && power_down_n_i)[*5] |=> !xcvr_enable_n_o && xcvr_direction_o && !host_byte_bus_oe_o)
    else $error("playback write not served");
  AST_PWRDN: assert property ((!power_down_n_i)[*4] |=> !capture_request_o && !playback_request_o && !irq_o && xcvr_enable_n_o)
    else $error("port active while powered down");
  AST_CAP_HOLD: assert property ($fell(capture_request_o) |-> cap_age_ff < 4'h8)
    else $error("capture request dropped without a read");
  AST_PLAY_HOLD: assert property ($fell(playback_request_o) |-> play_age_ff < 4'h8)
    else $error("playback request dropped without a write");
  AST_IRQ_CAUSE: assert property ($rose(irq_o) |-> cap_age_ff < 4'hC || play_age_ff < 4'hC)
    else $error("interrupt raised with no completed sample");
  AST_OPEN_DRAIN: assert property (ext_control_out_o == 2'h0)
    else $error("control output driven high");
  AST_XCTL_WRITE: assert property (!$stable(ext_control_out_oe_o) |->
      $past(!wr_n_i && !cs_n_i, 3) || $past(!power_down_n_i, 3))
    else $error("control output changed without a register write");
  AST_OE_DIR: assert property (host_byte_bus_oe_o |-> !xcvr_direction_o && !xcvr_enable_n_o)
    else $error("bus driven against the transceiver");
endmodule : bhp_port_asserts

bind bhp_port bhp_port_asserts bhp_port_asserts_i (
  .clk_i, .srst_i, .rd_n_i, .wr_n_i, .cs_n_i, .capture_ack_n_i, .playback_ack_n_i,
  .power_down_n_i, .host_byte_bus_oe_o, .capture_request_o, .playback_request_o,
  .xcvr_enable_n_o, .xcvr_direction_o, .irq_o, .ext_control_out_o, .ext_control_out_oe_o
);

// ### testbench/bhp_port_tb.sv
`timescale 1ns/100ps
module bhp_port_tb;
  import bhp_pkg::*;
  // --------------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------------
  logic        clk, srst, rd_n, wr_n, cs_n, cap_ack_n, play_ack_n, power_down_n;
  logic [1:0]  sel, ext_out, ext_oe;
  logic [7:0]  hdata, bus, dev_data, rdat;
  logic [2:0]  ctl;
  logic        dev_oe, cap_req, play_req, en_n, dir, irq, cap_taken, play_valid;
  logic        cap_valid, play_ready, crystal_sel, irq_exp;
  logic [31:0] cap_data, play_data, word;
  int          bad_count, checks_done, cnt, cnt_base;

  // Whoever enables drives the wire; the host releases to an inverted byte.
  assign bus = dev_oe ? dev_data : hdata;

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  bhp_port bhp_port_i (
    .clk_i(clk), .srst_i(srst), .rd_n_i(rd_n), .wr_n_i(wr_n), .cs_n_i(cs_n),
    .capture_ack_n_i(cap_ack_n), .playback_ack_n_i(play_ack_n), .reg_select_i(sel),
    .host_byte_bus_i(bus), .host_byte_bus_o(dev_data), .host_byte_bus_oe_o(dev_oe),
    .capture_request_o(cap_req), .playback_request_o(play_req),
    .xcvr_enable_n_o(en_n), .xcvr_direction_o(dir), .irq_o(irq),
    .ext_control_out_o(ext_out), .ext_control_out_oe_o(ext_oe),
    .power_down_n_i(power_down_n), .capture_valid_i(cap_valid),
    .capture_data_i(cap_data), .capture_taken_o(cap_taken),
    .playback_ready_i(play_ready), .playback_valid_o(play_valid),
    .playback_data_o(play_data), .crystal_sel_i(crystal_sel)
  );

  bhp_host_model bhp_host_model_i (
    .clk_i(clk), .bus_i(bus), .ctl_i({en_n, dir, dev_oe}), .rd_n_o(rd_n),
    .wr_n_o(wr_n), .cs_n_o(cs_n), .cap_ack_n_o(cap_ack_n),
    .play_ack_n_o(play_ack_n), .sel_o(sel), .data_o(hdata)
  );

  // --------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    if (bad_count == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish

  // Bounded wait on a request or the capture hand-off; a hang ends the run.
  task automatic wait_for(input int which, input logic lvl);
    int   n;
    logic v;
    n = 0;
    v = ~lvl;
    while (v !== lvl && n < 200) begin
      @(negedge clk);
      n++;
      v = (which == 0) ? cap_req : (which == 1) ? play_req : cap_taken;
    end
    if (v !== lvl) begin
      bad_count++;
      $display("Error at %0t: wait %0d timed out", $time, which);
      tally_and_finish();
    end
  endtask : wait_for

  task automatic hx(input logic rd, input logic c, input logic [1:0] a,
                    input logic [1:0] s, input logic [7:0] w);
    bhp_host_model_i.xfer(rd, c, a, s, w, rdat, ctl);
  endtask : hx

  // Sample counter model: a completed sample at zero underflows and reloads.
  task automatic sample_done();
    if (cnt == 0) begin
      irq_exp = 1'b1;
      cnt     = cnt_base;
    end else begin
      cnt--;
    end
    check(irq, irq_exp);
  endtask : sample_done

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial begin
    {srst, power_down_n} = 2'h3;
    {cap_valid, play_ready, crystal_sel, irq_exp} = 4'h0;
    cap_data = 32'h0;
    bad_count   = 0;
    checks_done = 0;
    cnt         = 0;
    cnt_base    = 1;
    void'($urandom(57));
    repeat (8) @(negedge clk);
    srst = 1'b0;
    repeat (3) @(negedge clk);
    check({en_n, dir, dev_oe, irq, cap_req, play_req, ext_out, ext_oe}, 10'h313);
    // A count base of one makes the counter alternate between reload and decrement.
    hx(1'b0, 1'b0, 2'b11, SEL_INDEX, {4'h0, IDX_CNT_LO});
    hx(1'b0, 1'b0, 2'b11, SEL_DATA, 8'(cnt_base));
    for (int r = 0; r < 3; r++) begin
      // Capture: bytes leave MSB first, left before right, chip select high.
      word      = $urandom;
      cap_data  = word;
      cap_valid = 1'b1;
      wait_for(2, 1'b1);
      cap_valid = 1'b0;
      wait_for(0, 1'b1);
      check(cap_req, 1'b1);
      for (int b = 0; b < 4; b++) begin
        hx(1'b1, 1'b1, 2'b01, 2'($urandom), 8'h00);
        check(rdat, word[31-8*b -: 8]);
        check(ctl, 3'b001);
        check(cap_req, b < 3);
      end
      sample_done();
      hx(1'b1, 1'b0, 2'b11, SEL_STATUS, 8'h00);
      check(rdat[2:0], {2'b10, irq_exp});
      hx(1'b0, 1'b0, 2'b11, SEL_STATUS, 8'h00);
      irq_exp = 1'b0;
      check(irq, irq_exp);
      // Playback: request holds through three bytes and drops on the fourth.
      word = $urandom;
      for (int b = 0; b < 4; b++) begin
        hx(1'b0, 1'b1, 2'b10, 2'($urandom), word[31-8*b -: 8]);
        check(ctl, 3'b010);
        check(play_req, b < 3);
      end
      check({play_valid, play_data}, {1'b1, word});
      sample_done();
      hx(1'b0, 1'b0, 2'b11, SEL_STATUS, 8'h00);
      irq_exp = 1'b0;
      play_ready = 1'b1;
      wait_for(1, 1'b1);
      play_ready = 1'b0;
      check({play_req, irq}, 2'h2);
    end
    // Control bits: the open-drain pair pulls low where a stored bit is 0.
    word = $urandom;
    hx(1'b0, 1'b0, 2'b11, SEL_INDEX, {4'h0, IDX_XCTL});
    hx(1'b0, 1'b0, 2'b11, SEL_DATA, word[7:0]);
    check({ext_out, ext_oe}, {2'b00, ~word[XCTL_POS +: 2]});
    hx(1'b0, 1'b1, 2'b11, SEL_DATA, ~word[7:0]);
    check({ctl, ext_oe}, {3'b110, ~word[XCTL_POS +: 2]});
    hx(1'b1, 1'b0, 2'b11, SEL_DATA, 8'h00);
    check(rdat[XCTL_POS +: 2], word[XCTL_POS +: 2]);
    // Power-down with a capture pending clears the whole port.
    cap_data  = $urandom;
    cap_valid = 1'b1;
    wait_for(0, 1'b1);
    cap_valid    = 1'b0;
    // A programmed-I/O read shows the top capture byte without consuming it.
    hx(1'b1, 1'b0, 2'b11, SEL_PIO, 8'h00);
    check({rdat, cap_req}, {cap_data[31:24], 1'b1});
    power_down_n = 1'b0;
    repeat (6) @(negedge clk);
    check({cap_req, play_req, irq, en_n}, 4'h1);
    power_down_n = 1'b1;
    repeat (4) @(negedge clk);
    tally_and_finish();
  end
endmodule : bhp_port_tb
